// ==== logic/lfflag_defines.vh ====
/*
  Offsets, field positions, reset values and bus layout of the LED fault flag registers.
  Assumes an 8-bit register address space and an 8-bit data path.
*/
`ifndef LFFLAG_DEFINES_VH
`define LFFLAG_DEFINES_VH

`define LFFLAG_ADDR_W            8
`define LFFLAG_DATA_W            8
`define LFFLAG_OFF_OPEN_CD       8'ha8
`define LFFLAG_OFF_OPEN_EF       8'ha9
`define LFFLAG_OFF_OPEN_GH       8'haa
`define LFFLAG_OFF_SHORT_AB      8'hab
`define LFFLAG_OFF_IRQ_STATUS    8'hb0
`define LFFLAG_OFF_IRQ_MASK      8'hb1
`define LFFLAG_FLAG_RESET        8'h00
`define LFFLAG_IRQ_MASK_RESET    8'h00
`define LFFLAG_LOW_GROUP_LSB     0
`define LFFLAG_HIGH_GROUP_LSB    4
`define LFFLAG_GROUP_W           3
`define LFFLAG_UNMAPPED_READ     8'h00
`define LFFLAG_SYNC_STAGES       3

`endif

// ==== logic/lfflag_sync.v ====
/*
  Three-stage synchroniser for a vector of fault levels from the analog detectors.
  Assumes the detector levels are asynchronous to clk_i; a bit changes once stages 2 and 3 agree.
*/
`default_nettype none

module lfflag_sync #(
  parameter WIDTH = 24
) (
  input  wire             clk_i,    // System clock.
  input  wire             rst_n_i,  // Synchronous reset, active low.
  input  wire [WIDTH-1:0] async_i,  // Raw fault levels.
  output reg  [WIDTH-1:0] level_o   // Filtered, synchronised levels.
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // Stage 1 is read only by stage 2, so metastability never reaches the filter.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      stage1  <= {WIDTH{1'b0}};
      stage2  <= {WIDTH{1'b0}};
      stage3  <= {WIDTH{1'b0}};
      level_o <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level_o <= (stage2 & stage3) | (level_o & (stage2 | stage3));
    end
  end

endmodule // lfflag_sync

`default_nettype wire

// ==== logic/lfflag_regs.v ====
/*
  Read-only LED fault flag registers: open flags for groups C/D, E/F, G/H and short flags
  for groups A/B, plus a sticky interrupt status and mask over the same flags.
  Assumes fault detector levels arrive asynchronously and a simple strobe register port.
*/
// What this block does
// RULE1: An open flag reads one while its output shows an open fault, else zero.
// RULE2: Open register C/D holds D2..D0 in bits 6..4, C2..C0 in 2..0, bit 3 zero.
// RULE3: Open register at A9h resets to 00h; F in 6..4, E in 2..0, reserved zero.
// RULE4: Open register at AAh resets to 00h; H in 6..4, G in 2..0, reserved zero.
// RULE5: Short register at ABh resets to 00h; B in 6..4, A in 2..0, reserved zero.
// RULE6: A short flag reads one while its output is shorted; all flags are read-only.
// RULE7: Host writes to any flag register are ignored and change nothing.
`include "lfflag_defines.vh"
`default_nettype none

module lfflag_regs #(
  parameter NUM_REGS = 4
) (
  input  wire       clk_i,              // 40 MHz clock.
  input  wire       rst_n_i,            // Synchronous reset, active low.
  input  wire [2:0] open_fault_c_i,     // Open detector levels, outputs C2..C0.
  input  wire [2:0] open_fault_d_i,     // Open detector levels, outputs D2..D0.
  input  wire [2:0] open_fault_e_i,     // Open detector levels, outputs E2..E0.
  input  wire [2:0] open_fault_f_i,     // Open detector levels, outputs F2..F0.
  input  wire [2:0] open_fault_g_i,     // Open detector levels, outputs G2..G0.
  input  wire [2:0] open_fault_h_i,     // Open detector levels, outputs H2..H0.
  input  wire [2:0] short_fault_a_i,    // Short detector levels, outputs A2..A0.
  input  wire [2:0] short_fault_b_i,    // Short detector levels, outputs B2..B0.
  input  wire [7:0] addr_i,             // Register address.
  input  wire [7:0] wdata_i,            // Write data.
  input  wire       wr_i,               // Write strobe.
  input  wire       rd_i,               // Read strobe.
  output reg  [7:0] rdata_o,            // Read data, valid the cycle after rd_i.
  output wire       irq_o               // Level interrupt, unmasked status set.
);

  localparam DW = `LFFLAG_DATA_W;

  // Register index within the flag bank: 0 C/D, 1 E/F, 2 G/H, 3 short A/B.
  function [2:0] flag_index;
    input [7:0] addr;
    begin
      case (addr)
        `LFFLAG_OFF_OPEN_CD:  flag_index = 3'h0;
        `LFFLAG_OFF_OPEN_EF:  flag_index = 3'h1;
        `LFFLAG_OFF_OPEN_GH:  flag_index = 3'h2;
        `LFFLAG_OFF_SHORT_AB: flag_index = 3'h3;
        default:              flag_index = 3'h4;
      endcase
    end
  endfunction

  wire [NUM_REGS*6-1:0] raw_faults;
  wire [NUM_REGS*6-1:0] sync_faults;

  assign raw_faults = {short_fault_b_i, short_fault_a_i,
                       open_fault_h_i,  open_fault_g_i,
                       open_fault_f_i,  open_fault_e_i,
                       open_fault_d_i,  open_fault_c_i};

  lfflag_sync #(
    .WIDTH (NUM_REGS*6)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (raw_faults),
    .level_o (sync_faults)
  );

  // Flag registers: each follows its detector; the bus has no write path into them.
  reg  [DW-1:0] flag_reg [0:NUM_REGS-1];
  wire [DW-1:0] next_flag [0:NUM_REGS-1];
  reg  [DW-1:0] irq_status;
  reg  [DW-1:0] irq_mask;
  wire [DW-1:0] rise [0:NUM_REGS-1];

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1) begin : g_flag
      // Low group in bits 2..0, high group in 6..4, bits 7 and 3 forced to zero.
      assign next_flag[g] = {1'b0, sync_faults[g*6+5 -: `LFFLAG_GROUP_W],      // RULE2
                             1'b0, sync_faults[g*6+2 -: `LFFLAG_GROUP_W]};     // RULE3
      assign rise[g] = next_flag[g] & ~flag_reg[g];

      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          flag_reg[g] <= `LFFLAG_FLAG_RESET;                                   // RULE4
        end else begin
          flag_reg[g] <= next_flag[g];                                         // RULE1
        end
      end
    end
  endgenerate

  // Any new fault in a register sets that register's status bit; bits 3..0 map regs 3..0.
  wire [DW-1:0] irq_event;
  assign irq_event = {4'h0, |rise[3], |rise[2], |rise[1], |rise[0]};

  wire wr_status;
  wire wr_mask;
  assign wr_status = wr_i && (addr_i == `LFFLAG_OFF_IRQ_STATUS);
  assign wr_mask   = wr_i && (addr_i == `LFFLAG_OFF_IRQ_MASK);

  // A new event in the same cycle as a write-one clear keeps its bit set.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_status <= `LFFLAG_FLAG_RESET;
      irq_mask   <= `LFFLAG_IRQ_MASK_RESET;
    end else begin
      if (wr_status) begin
        irq_status <= (irq_status & ~wdata_i) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      if (wr_mask) begin
        irq_mask <= wdata_i & 8'h0f;
      end
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // Writes to the flag offsets decode to nothing and are dropped.
  reg [DW-1:0] next_rdata;
  reg [2:0]    rd_idx;
  always @* begin
    rd_idx     = flag_index(addr_i);
    next_rdata = `LFFLAG_UNMAPPED_READ;
    if (rd_idx < NUM_REGS) begin
      next_rdata = flag_reg[rd_idx[1:0]];                                      // RULE6 RULE7
    end else if (addr_i == `LFFLAG_OFF_IRQ_STATUS) begin
      next_rdata = irq_status;
    end else if (addr_i == `LFFLAG_OFF_IRQ_MASK) begin
      next_rdata = irq_mask;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;                                                   // RULE5
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // lfflag_regs

`default_nettype wire

// ==== sim/lfflag_checker.sv ====
/* Assertions on the fault flag register port.
   Assumes it is bound to lfflag_regs and sees only its ports. */
`default_nettype none
module lfflag_checker (
  input wire logic       clk_i,            // Clock.
  input wire logic       rst_n_i,          // Reset.
  input wire logic [2:0] open_fault_c_i,   // Opens C.
  input wire logic [2:0] open_fault_d_i,   // Opens D.
  input wire logic [2:0] open_fault_e_i,   // Opens E.
  input wire logic [2:0] open_fault_f_i,   // Opens F.
  input wire logic [2:0] open_fault_g_i,   // Opens G.
  input wire logic [2:0] open_fault_h_i,   // Opens H.
  input wire logic [2:0] short_fault_a_i,  // Shorts A.
  input wire logic [2:0] short_fault_b_i,  // Shorts B.
  input wire logic [7:0] addr_i,           // Address.
  input wire logic       rd_i,             // Read.
  input wire logic       wr_i,             // Write.
  input wire logic [7:0] rdata_o,          // Read data.
  input wire logic       irq_o             // Interrupt.
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Flags pass a filter of several stages, so only levels held seven cycles are compared.
  property p_live(logic [7:0] a, logic [2:0] hi, logic [2:0] lo);
    ($stable(hi) && $stable(lo))[*7] ##1 (rd_i && addr_i == a)
      |=> rdata_o == {1'b0, $past(hi, 2), 1'b0, $past(lo, 2)};
  endproperty
  AST_LIVE_CD: assert property (p_live(8'ha8, open_fault_d_i, open_fault_c_i))
    else $error("open flags c d wrong");
  AST_LIVE_EF: assert property (p_live(8'ha9, open_fault_f_i, open_fault_e_i))
    else $error("open flags e f wrong");
  AST_LIVE_GH: assert property (p_live(8'haa, open_fault_h_i, open_fault_g_i))
    else $error("open flags g h wrong");
  AST_LIVE_AB: assert property (p_live(8'hab, short_fault_b_i, short_fault_a_i))
    else $error("short flags a b wrong");
  AST_RESERVED: assert property (rd_i && addr_i[7:2] == 6'h2a |=>
    rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0)
    else $error("reserved bit set");
  AST_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read");
  AST_RESET: assert property (($rose(rst_n_i) && rd_i) |=> rdata_o == 8'h00)
    else $error("flags not clear after reset");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wr_i))
    else $error("interrupt dropped without write");
  cover property (rd_i && addr_i == 8'hab);
  cover property ($rose(irq_o));
  cover property ($fell(irq_o));
endmodule // lfflag_checker
`default_nettype wire

// ==== sim/lfflag_regs_bench.sv ====
/* Self-checking bench for the fault flag registers.
   Assumes the register port and interrupt map of lfflag_regs. */
`default_nettype none
module lfflag_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, irq_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [2:0] flt [8] = '{default: 3'h0};
  int         seed = 38090, failures = 0, comparisons = 0, cycles = 0;
  lfflag_regs u_lfflag_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .open_fault_c_i(flt[0]),
    .open_fault_d_i(flt[1]), .open_fault_e_i(flt[2]), .open_fault_f_i(flt[3]),
    .open_fault_g_i(flt[4]), .open_fault_h_i(flt[5]), .short_fault_a_i(flt[6]),
    .short_fault_b_i(flt[7]), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus tasks start and end on a rising edge; read data is looked at mid-cycle, where it stands.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check("rdata_o", rdata_o, exp);
    @(posedge clk_i);
  endtask
  // The strobe rests low for one edge, so two writes never drive it twice in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic irq_is(input logic exp);
    @(negedge clk_i);
    check("irq_o", {7'h00, irq_o}, {7'h00, exp});
    @(posedge clk_i);
  endtask
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'ha9, 8'h00);
    rd(8'haa, 8'h00);
    rd(8'hab, 8'h00);
    rd(8'h50, 8'h00);
    for (int n = 0; n < 20; n++) begin
      @(posedge clk_i);
      foreach (flt[i]) flt[i] <= 3'($random(seed));
      repeat (8) @(posedge clk_i);
      // A random write lands before each read; the read still expects the detector levels, so a flag that took the data fails.
      for (int k = 0; k < 4; k++) begin
        wr(8'(8'ha8 + k), 8'($random(seed)));
        rd(8'(8'ha8 + k), {1'b0, flt[2*k+1], 1'b0, flt[2*k]});
      end
    end
    // Faults held through a second reset must read as clear until the filter refills.
    foreach (flt[i]) flt[i] <= 3'h7;
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'hab, 8'h00);
    repeat (8) @(posedge clk_i);
    rd(8'hab, 8'h77);
    foreach (flt[i]) flt[i] <= 3'h0;
    repeat (8) @(posedge clk_i);
    wr(8'hb0, 8'hff);
    wr(8'hb1, 8'h0f);
    flt[2] <= 3'h1;
    repeat (8) @(posedge clk_i);
    irq_is(1'b1);
    rd(8'hb0, 8'h02);
    wr(8'hb1, 8'h00);
    irq_is(1'b0);
    wr(8'hb1, 8'h0f);
    irq_is(1'b1);
    wr(8'hb0, 8'h02);
    irq_is(1'b0);
    close_out;
  end
endmodule // lfflag_regs_bench
bind lfflag_regs lfflag_checker u_lfflag_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .open_fault_c_i(open_fault_c_i), .open_fault_d_i(open_fault_d_i),
  .open_fault_e_i(open_fault_e_i), .open_fault_f_i(open_fault_f_i),
  .open_fault_g_i(open_fault_g_i), .open_fault_h_i(open_fault_h_i),
  .short_fault_a_i(short_fault_a_i), .short_fault_b_i(short_fault_b_i),
  .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire
